/* File: hw/indicator_ttl_pkg.sv */
// constants and carriers for the per-processor indicator and ttl register
package indicator_ttl_pkg;

    // number of processors sharing the logic device
    localparam int NUM_PROC = 4;

    // chip-select region three decode: 1 MB window at the base address
    localparam logic [31:0] REGION_BASE = 32'hB000_0000;
    localparam logic [31:0] REGION_MASK = 32'hFFF0_0000;

    // absolute address of the output register, same for every processor
    localparam logic [31:0] CTRL_ADDR = 32'hB00D_0000;

    // field positions and reset value
    localparam int LAMP_BIT = 0;
    localparam int TTL_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // one processor's memory-interface access, strobes active low
    typedef struct packed {
        logic ce3N;
        logic weN;
        logic reN;
        logic [31:0] addr;
        logic [31:0] wdata;
    } emif_req_t;

    // registered read answer towards one processor
    typedef struct packed {
        logic valid;
        logic [31:0] data;
    } emif_resp_t;

endpackage : indicator_ttl_pkg

/* File: hw/indicator_ttl_output_reg.sv */
// per-processor indicator lamp and ttl output register, config lamp
// Functional notes
// [RULE1] register at same absolute address for all
// [RULE2] bit zero lights lamp, zero extinguishes
// [RULE3] each processor owns one lamp, one ttl
// [RULE4] ttl bit one, lamp bit zero, reset zero
// [RULE5] four ttl outputs, one per processor
// [RULE6] config lamp on while done low
// [RULE7] software writes zeros to upper bits
// [RULE8] decode only inside chip-select region three
// [RULE9] read returns both bits, upper bits zero
`timescale 1ns/1ns
module indicator_ttl_output_reg
    import indicator_ttl_pkg::*;
(
    // clock and synchronous reset
    input wire logic clock,
    input wire logic rst,
    // memory-interface slave ports, one per processor
    input wire emif_req_t [NUM_PROC-1:0] memReq,
    output emif_resp_t [NUM_PROC-1:0] memResp,
    // configuration-complete pin of the logic device
    input wire logic configDone,
    // board outputs, high means lit / driven high
    output logic [NUM_PROC-1:0] lamp,
    output logic [NUM_PROC-1:0] ttlOut,
    output logic configLamp
);

    // whole module state
    typedef struct packed {
        logic [NUM_PROC-1:0][1:0] ctrl;
        emif_resp_t [NUM_PROC-1:0] resp;
        logic doneMeta;
        logic doneSync;
        logic cfgLamp;
    } state_t;

    state_t state;
    state_t next_state;
    logic [NUM_PROC-1:0] inRegion;
    logic [NUM_PROC-1:0] regHit;

    // address decode per processor; full compare keeps every view identical
    always_comb
    begin
        for (int i = 0; i < NUM_PROC; i++)
        begin
            inRegion[i] = !memReq[i].ce3N
                && ((memReq[i].addr & REGION_MASK) == REGION_BASE); // RULE8
            regHit[i] = inRegion[i] && (memReq[i].addr == CTRL_ADDR); // RULE1
        end
    end

    // next state: writes, reads and the done synchroniser
    always_comb
    begin
        next_state = state;
        for (int i = 0; i < NUM_PROC; i++)
        begin
            next_state.resp[i].valid = 1'b0;
            next_state.resp[i].data = READ_ZERO;
            // only processor i's own port reaches its own bits
            if (regHit[i] && !memReq[i].weN)
            begin
                // upper bits are dropped; software keeps them zero
                next_state.ctrl[i][LAMP_BIT] =
                    memReq[i].wdata[LAMP_BIT]; // RULE2 RULE3
                next_state.ctrl[i][TTL_BIT] =
                    memReq[i].wdata[TTL_BIT]; // RULE4
            end
            // any read inside the region is answered, unmapped reads zero
            if (inRegion[i] && !memReq[i].reN)
            begin
                next_state.resp[i].valid = 1'b1;
                if (regHit[i])
                begin
                    next_state.resp[i].data = {30'h0, state.ctrl[i]}; // RULE9
                end
            end
        end
        // pin is asynchronous to clock, so two flops before use
        next_state.doneMeta = configDone;
        next_state.doneSync = state.doneMeta;
        next_state.cfgLamp = !state.doneSync; // RULE6
        if (rst)
        begin
            next_state = '0;
            for (int i = 0; i < NUM_PROC; i++)
            begin
                next_state.ctrl[i] = CTRL_RESET; // RULE4
            end
            // lamp lit until done is seen, as after power-up
            next_state.cfgLamp = 1'b1;
        end
    end

    // single state register
    always_ff @(posedge clock)
    begin
        state <= next_state;
    end

    // outputs straight from the state flops
    always_comb
    begin
        memResp = state.resp;
        configLamp = state.cfgLamp;
        for (int i = 0; i < NUM_PROC; i++)
        begin
            lamp[i] = state.ctrl[i][LAMP_BIT]; // RULE2
            ttlOut[i] = state.ctrl[i][TTL_BIT]; // RULE5
        end
    end

    // per-processor checks
    for (genvar g = 0; g < NUM_PROC; g++)
    begin : g_check
        lamp_write_a: assert property ( // RULE2
            @(posedge clock) disable iff (rst)
            (!memReq[g].ce3N && !memReq[g].weN && memReq[g].addr == CTRL_ADDR)
            |=> lamp[g] == $past(memReq[g].wdata[0]))
            else $error("lamp does not follow written bit zero");

        ttl_write_a: assert property ( // RULE5
            @(posedge clock) disable iff (rst)
            (!memReq[g].ce3N && !memReq[g].weN && memReq[g].addr == CTRL_ADDR)
            |=> ttlOut[g] == $past(memReq[g].wdata[1]))
            else $error("ttl output does not follow written bit one");

        own_port_a: assert property ( // RULE3
            @(posedge clock) disable iff (rst)
            !(!memReq[g].ce3N && !memReq[g].weN) && !$past(rst)
            |=> $stable(lamp[g]) && $stable(ttlOut[g]))
            else $error("output changed without own write");

        region_decode_a: assert property ( // RULE8
            @(posedge clock) disable iff (rst)
            (!memReq[g].ce3N && !memReq[g].reN
                && (memReq[g].addr & REGION_MASK) != REGION_BASE)
            |=> !memResp[g].valid)
            else $error("read answered outside region three");

        // unmapped addresses inside the region answer, but only zero
        unmapped_read_a: assert property ( // RULE8
            @(posedge clock) disable iff (rst)
            (!memReq[g].ce3N && !memReq[g].reN
                && (memReq[g].addr & REGION_MASK) == REGION_BASE
                && memReq[g].addr != CTRL_ADDR)
            |=> memResp[g].valid && memResp[g].data == READ_ZERO)
            else $error("unmapped read not answered with zero");

        // an answer never appears without a read strobe before it
        read_pulse_a: assert property ( // RULE9
            @(posedge clock) disable iff (rst)
            !(!memReq[g].ce3N && !memReq[g].reN)
            |=> !memResp[g].valid)
            else $error("read answer without a read strobe");

        // idle answer lines rest at zero so a stray latch sees nothing
        resp_quiet_a: assert property ( // RULE9
            @(posedge clock) disable iff (rst)
            !memResp[g].valid |-> memResp[g].data == READ_ZERO)
            else $error("answer data not zero while idle");

        // reserved bits of every answer read as zero
        upper_zero_a: assert property ( // RULE9
            @(posedge clock) disable iff (rst)
            memResp[g].data[31:2] == 30'h0)
            else $error("reserved answer bits not zero");

        // a deselected write strobe must not reach the register
        deselect_write_a: assert property ( // RULE3
            @(posedge clock) disable iff (rst)
            (memReq[g].ce3N && !memReq[g].weN && !$past(rst))
            |=> $stable(lamp[g]) && $stable(ttlOut[g]))
            else $error("write without chip select took effect");

        read_back_a: assert property ( // RULE9
            @(posedge clock) disable iff (rst)
            (!memReq[g].ce3N && !memReq[g].reN && memReq[g].addr == CTRL_ADDR)
            |=> memResp[g].valid
                && memResp[g].data == {30'h0, $past(ttlOut[g]),
                    $past(lamp[g])})
            else $error("read back value wrong");

        alias_addr_a: assert property ( // RULE1
            @(posedge clock) disable iff (rst)
            (!memReq[g].ce3N && !memReq[g].weN
                && memReq[g].addr == 32'hB00D_0004)
            |=> $stable(lamp[g]) && $stable(ttlOut[g]))
            else $error("neighbour address altered the register");
    end

    // reset and configuration lamp checks
    reset_zero_a: assert property ( // RULE4
        @(posedge clock)
        $past(rst) |-> lamp == 4'h0 && ttlOut == 4'h0 && configLamp)
        else $error("outputs not cleared by reset");

    config_lamp_a: assert property ( // RULE6
        @(posedge clock) disable iff (rst)
        !$past(rst) && !$past(rst, 2) && !$past(rst, 3)
        |-> configLamp == !$past(configDone, 3))
        else $error("config lamp not the inverse of done");

endmodule : indicator_ttl_output_reg

/* File: verif/emif_master.sv */
// memory-interface master model driving all processor ports
`timescale 1ns/1ns
module emif_master
    import indicator_ttl_pkg::*;
(
    // clock
    input wire logic clock,
    // bus towards the device
    output emif_req_t [NUM_PROC-1:0] req,
    input wire emif_resp_t [NUM_PROC-1:0] resp
);
    // strobes idle high from time zero
    initial req = '1;
    // one access: held for its edge, then released with inverted lines
    // so a stale address or data word can never pass for a live one
    task automatic acc(input int p, input logic w, input logic [31:0] a,
        input logic [31:0] d, output logic [32:0] r);
        @(posedge clock);
        req[p] <= '{1'b0, !w, w, a, d};
        @(posedge clock);
        req[p] <= '{1'b1, 1'b1, 1'b1, ~a, ~d};
        // registered answer stands until the next edge; read it settled
        #1 r = resp[p];
    endtask : acc
endmodule : emif_master

/* File: verif/tb.sv */
// self-checking bench for the indicator and ttl register
`timescale 1ns/1ns
module tb;
    import indicator_ttl_pkg::*;
    logic clock = 0;
    logic rst = 1;
    logic configDone = 0;
    emif_req_t [NUM_PROC-1:0] memReq;
    emif_resp_t [NUM_PROC-1:0] memResp;
    logic [NUM_PROC-1:0] lamp;
    logic [NUM_PROC-1:0] ttlOut;
    logic configLamp;
    logic [1:0] shadow [NUM_PROC];
    logic [1:0] v;
    logic [32:0] r;
    int p;
    int err_count = 0;
    int tests_run = 0;
    always #5 clock = ~clock;
    emif_master bus_u (.clock, .req(memReq), .resp(memResp));
    indicator_ttl_output_reg dut_u (.clock, .rst, .memReq, .memResp,
        .configDone, .lamp, .ttlOut, .configLamp);
    // compare and count
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        tests_run++;
        if (got !== exp)
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        if (got !== exp)
            err_count++;
    endtask : chk
    // expected read answer: valid, upper bits zero, ttl then lamp
    function automatic logic [32:0] rdexp(input logic [1:0] x);
        return {1'b1, 30'h0, x};
    endfunction : rdexp
    task automatic conclude;
        $display("errors %0d checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : conclude
    // watchdog, far beyond the few hundred cycles the tests need
    initial
    begin
        #20000;
        err_count++;
        conclude();
    end
    initial
    begin
        void'($urandom(32'h89531454));
        repeat (20) @(posedge clock);
        rst <= 0;
        repeat (3) @(posedge clock);
        #1 chk({lamp, ttlOut, configLamp}, 9'h001);
        for (int q = 0; q < NUM_PROC; q++)
        begin
            shadow[q] = CTRL_RESET;
            bus_u.acc(q, 0, CTRL_ADDR, 32'h0, r);
            chk(r, rdexp(2'h0));
        end
        // random writes, all four ports checked against their own shadows
        repeat (40)
        begin
            p = $urandom_range(NUM_PROC - 1);
            v = 2'($urandom_range(3));
            bus_u.acc(p, 1, CTRL_ADDR, {30'h0, v}, r);
            shadow[p] = v;
            #1;
            for (int q = 0; q < NUM_PROC; q++)
                chk({ttlOut[q], lamp[q]}, shadow[q]);
            bus_u.acc(p, 0, CTRL_ADDR, 32'h0, r);
            chk(r, rdexp(v));
        end
        // other address in region: write ignored, read answers zero
        bus_u.acc(0, 1, CTRL_ADDR + 32'h4, 32'h3, r);
        bus_u.acc(0, 0, CTRL_ADDR + 32'h4, 32'h0, r);
        chk(r, rdexp(2'h0));
        bus_u.acc(0, 0, CTRL_ADDR, 32'h0, r);
        chk(r, rdexp(shadow[0]));
        bus_u.acc(1, 0, 32'hA00D_0000, 32'h0, r);
        chk(r, 33'h0);
        // configuration completes: lamp goes dark
        @(posedge clock);
        configDone <= 1;
        repeat (4) @(posedge clock);
        #1 chk(configLamp, 1'b0);
        // second reset in mid-run clears outputs that were surely set
        bus_u.acc(0, 1, CTRL_ADDR, 32'h3, r);
        #1 chk({ttlOut[0], lamp[0]}, 2'h3);
        @(posedge clock);
        rst <= 1;
        @(posedge clock);
        rst <= 0;
        #1 chk({lamp, ttlOut, configLamp}, 9'h001);
        conclude();
    end
endmodule : tb
